/* File: hdl/l2lru_pkg.sv */
// Shared constants and types for the cache replacement-state block
package l2lru_pkg;

   // ==========================================================
   // Organisation
   localparam int L2LRU_WAYS = 4;
   localparam int L2LRU_WAY_BITS = 2;
   localparam int L2LRU_RANK_BITS = 2;
   localparam int L2LRU_LINE_BYTES = 128;
   localparam int L2LRU_OFFSET_BITS = 7;
   localparam int L2LRU_SETS_PER_GROUP = 4;
   localparam int L2LRU_GROUP_SPAN_BYTES = 512;
   localparam int L2LRU_ADDR_BITS = 32;

   // ==========================================================
   // Rank encoding and reset values
   localparam logic [1:0] L2LRU_RANK_LRU = 2'h0;
   localparam logic [1:0] L2LRU_RANK_MRU = 2'h3;
   // Way n holds rank n after reset: way 0 is least recent
   localparam logic [7:0] L2LRU_RANK_RESET = 8'hE4;
   localparam logic [31:0] L2LRU_RAM_BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] L2LRU_RAM_SIZE_RESET = 32'h0004_0000;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      L2LRU_SRC_PROG,
      L2LRU_SRC_DATA,
      L2LRU_SRC_DMA
   } l2lru_src_t;

   typedef enum logic {
      L2LRU_ST_IDLE,
      L2LRU_ST_BLOCK
   } l2lru_state_t;

endpackage : l2lru_pkg

/* File: hdl/l2lru_order.sv */
// Per-set way ordering: victim choice and promotion of the used way
`timescale 1ns/100ps
`default_nettype none
module l2lru_order import l2lru_pkg::*; (
   // Current set state
   input wire logic [7:0] ranks_in,
   input wire logic [3:0] valid_in,
   // Access
   input wire logic hit,
   input wire logic [1:0] hit_way,
   // Results
   output logic [1:0] victim_way,
   output logic [7:0] ranks_out
);

   logic [1:0] use_way;
   logic [1:0] use_rank;

   // ==========================================================
   // Victim: lowest invalid way, else the least recent way
   always_comb begin
      victim_way = 2'h0;
      for (int w = L2LRU_WAYS - 1; w >= 0; w--) begin
         if (ranks_in[w*L2LRU_RANK_BITS +: L2LRU_RANK_BITS] == L2LRU_RANK_LRU) begin
            victim_way = 2'(w);
         end
      end
      for (int w = L2LRU_WAYS - 1; w >= 0; w--) begin
         if (!valid_in[w]) begin
            victim_way = 2'(w);
         end
      end
   end

   always_comb begin
      use_way = hit ? hit_way : victim_way;
      use_rank = ranks_in[use_way*L2LRU_RANK_BITS +: L2LRU_RANK_BITS];
   end

   // ==========================================================
   // Promote used way, age only ways more recent than it
   generate
      for (genvar w = 0; w < L2LRU_WAYS; w++) begin : g_rank
         logic [1:0] r;
         assign r = ranks_in[w*L2LRU_RANK_BITS +: L2LRU_RANK_BITS];
         assign ranks_out[w*L2LRU_RANK_BITS +: L2LRU_RANK_BITS] =
            (use_way == 2'(w)) ? L2LRU_RANK_MRU :
            (r > use_rank) ? r - 2'h1 : r;
      end
   endgenerate

endmodule : l2lru_order
`default_nettype wire

/* File: hdl/l2lru_cache.sv */
// Four-way cache tag and replacement-state controller
//
// How it works
// - Four ways per set; the set comes from address bits, one line per way.
// - A processor hit finds the holding way and makes it most recent.
// - Allocation into a full set evicts its least recently used way.
// - Allocation takes an invalid way of the set before consulting order.
// - Block invalidate and block write-back-invalidate walk a line range.
// - Processor accesses to on-chip RAM leave replacement state unchanged.
// - Requester (DMA) accesses to on-chip RAM never touch replacement order.
// - On-chip RAM addresses map to sets exactly like external addresses.
// - Order is stored in words of four consecutive sets each.
// - A hit writes only its own set's slice of the group word.
// - Sets step every 128 bytes; four sets span 512 bytes.
// - Program fetches and data accesses to on-chip RAM are both accepted.
`timescale 1ns/100ps
`default_nettype none
module l2lru_cache import l2lru_pkg::*; #(
   parameter int SETS = 64,
   parameter logic [31:0] RAM_BASE = L2LRU_RAM_BASE_RESET,
   parameter logic [31:0] RAM_SIZE = L2LRU_RAM_SIZE_RESET
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Access request
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire l2lru_src_t req_src,
   input wire logic req_alloc,
   output logic req_ready,
   // Access result
   output logic rsp_valid,
   output logic rsp_ram,
   output logic rsp_hit,
   output logic [1:0] rsp_way,
   output logic [$clog2(SETS)-1:0] rsp_set,
   // Eviction or write-back of a valid line
   output logic evict_valid,
   output logic [31:0] evict_addr,
   // Block operations
   input wire logic blk_start,
   input wire logic blk_wbinv,
   input wire logic [31:0] blk_addr,
   input wire logic [15:0] blk_lines,
   output logic blk_busy,
   output logic blk_done
);

   localparam int SET_BITS = $clog2(SETS);
   localparam int GROUPS = SETS / L2LRU_SETS_PER_GROUP;
   localparam int GRP_BITS = SET_BITS - 2;
   localparam int TAG_W = L2LRU_ADDR_BITS - L2LRU_OFFSET_BITS - SET_BITS;

   // ==========================================================
   // Storage
   logic [TAG_W-1:0] tag_q [SETS][L2LRU_WAYS];
   logic [SETS-1:0][L2LRU_WAYS-1:0] valid_q;
   logic [GROUPS-1:0][L2LRU_SETS_PER_GROUP-1:0][7:0] lru_q;
   l2lru_state_t state_q;
   logic [31:0] blk_ptr_q;
   logic [15:0] blk_left_q;
   logic blk_wbinv_q;

   // ==========================================================
   // Address decoding
   function automatic logic [SET_BITS-1:0] set_of(input logic [31:0] a);
      return a[L2LRU_OFFSET_BITS +: SET_BITS];
   endfunction : set_of

   function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
      return a[L2LRU_ADDR_BITS-1 -: TAG_W];
   endfunction : tag_of

   function automatic logic [1:0] way_of(input logic [3:0] hv);
      logic [1:0] w;
      w = 2'h0;
      for (int i = L2LRU_WAYS - 1; i >= 0; i--) begin
         if (hv[i]) begin
            w = 2'(i);
         end
      end
      return w;
   endfunction : way_of

   logic start_ok, req_ok;
   logic [31:0] cur_addr;
   logic [SET_BITS-1:0] cur_set;
   logic [GRP_BITS-1:0] cur_grp;
   logic [1:0] cur_slot;
   logic [TAG_W-1:0] cur_tag;
   logic [3:0] hit_vec;
   logic cur_hit, cur_ram, cur_dma;
   logic [1:0] hit_way, victim_way;
   logic [7:0] ranks_new;
   logic lru_upd, do_alloc, blk_step;

   assign start_ok = (state_q == L2LRU_ST_IDLE) && blk_start;
   assign req_ok = (state_q == L2LRU_ST_IDLE) && !blk_start && req_valid;
   assign blk_step = (state_q == L2LRU_ST_BLOCK) && (blk_left_q != 16'h0);
   assign cur_addr = (state_q == L2LRU_ST_BLOCK) ? blk_ptr_q : req_addr;
   assign cur_set = set_of(cur_addr);
   assign cur_grp = cur_set[SET_BITS-1:2];
   assign cur_slot = cur_set[1:0];
   assign cur_tag = tag_of(cur_addr);
   assign cur_ram = (cur_addr - RAM_BASE) < RAM_SIZE;
   assign cur_dma = (req_src == L2LRU_SRC_DMA);

   always_comb begin
      for (int w = 0; w < L2LRU_WAYS; w++) begin
         hit_vec[w] = valid_q[cur_set][w] && (tag_q[cur_set][w] == cur_tag);
      end
   end
   assign cur_hit = |hit_vec && !cur_ram;
   assign hit_way = way_of(hit_vec);

   l2lru_order u_order (
      .ranks_in(lru_q[cur_grp][cur_slot]),
      .valid_in(valid_q[cur_set]),
      .hit(cur_hit),
      .hit_way(hit_way),
      .victim_way(victim_way),
      .ranks_out(ranks_new)
   );

   // RAM and requester accesses never reach the order update
   assign lru_upd = req_ok && !cur_ram && !cur_dma && (cur_hit || req_alloc);
   assign do_alloc = req_ok && !cur_ram && !cur_dma && !cur_hit && req_alloc;

   // ==========================================================
   // Replacement order, own slice only
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int g = 0; g < GROUPS; g++) begin
            for (int s = 0; s < L2LRU_SETS_PER_GROUP; s++) begin
               lru_q[g][s] <= L2LRU_RANK_RESET;
            end
         end
      end else if (lru_upd) begin
         lru_q[cur_grp][cur_slot] <= ranks_new;
      end
   end

   // ==========================================================
   // Tags and valid bits
   always_ff @(posedge clk) begin
      if (do_alloc) begin
         tag_q[cur_set][victim_way] <= cur_tag;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_q <= '0;
      end else if (do_alloc) begin
         valid_q[cur_set][victim_way] <= 1'b1;
      end else if (blk_step && cur_hit) begin
         valid_q[cur_set][hit_way] <= 1'b0;
      end
   end

   // ==========================================================
   // Block operation sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= L2LRU_ST_IDLE;
         blk_ptr_q <= 32'h0000_0000;
         blk_left_q <= 16'h0000;
         blk_wbinv_q <= 1'b0;
      end else begin
         unique case (state_q)
            L2LRU_ST_IDLE: begin
               if (start_ok) begin
                  state_q <= L2LRU_ST_BLOCK;
                  blk_ptr_q <= blk_addr;
                  blk_left_q <= blk_lines;
                  blk_wbinv_q <= blk_wbinv;
               end
            end
            L2LRU_ST_BLOCK: begin
               if (blk_left_q <= 16'h0001) begin
                  state_q <= L2LRU_ST_IDLE;
                  blk_left_q <= 16'h0000;
               end else begin
                  blk_left_q <= blk_left_q - 16'h0001;
               end
               blk_ptr_q <= blk_ptr_q + 32'(L2LRU_LINE_BYTES);
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req_ready <= 1'b0;
         blk_busy <= 1'b0;
         blk_done <= 1'b0;
      end else begin
         req_ready <= !start_ok && !(state_q == L2LRU_ST_BLOCK && blk_left_q > 16'h0001);
         blk_busy <= start_ok || (state_q == L2LRU_ST_BLOCK && blk_left_q > 16'h0001);
         blk_done <= (state_q == L2LRU_ST_BLOCK) && (blk_left_q <= 16'h0001);
      end
   end

   // ==========================================================
   // Access result and eviction outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_ram <= 1'b0;
         rsp_hit <= 1'b0;
         rsp_way <= 2'h0;
         rsp_set <= '0;
      end else begin
         rsp_valid <= req_ok;
         if (req_ok) begin
            rsp_ram <= cur_ram;
            rsp_hit <= cur_hit;
            rsp_way <= cur_hit ? hit_way : victim_way;
            rsp_set <= cur_set;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         evict_valid <= 1'b0;
         evict_addr <= 32'h0000_0000;
      end else begin
         evict_valid <= 1'b0;
         if (do_alloc && valid_q[cur_set][victim_way]) begin
            evict_valid <= 1'b1;
            evict_addr <= {tag_q[cur_set][victim_way], cur_set, 7'h00};
         end else if (blk_step && cur_hit && blk_wbinv_q) begin
            evict_valid <= 1'b1;
            evict_addr <= {cur_addr[31:L2LRU_OFFSET_BITS], 7'h00};
         end
      end
   end

   // ==========================================================
   // Checks
   logic [GROUPS-1:0][L2LRU_SETS_PER_GROUP-1:0][7:0] lru_hist_q;
   logic [SETS-1:0][L2LRU_WAYS-1:0] valid_hist_q;
   logic others_same;
   logic [7:0] rsp_ranks;

   always_ff @(posedge clk) begin
      lru_hist_q <= lru_q;
      valid_hist_q <= valid_q;
   end

   always_comb begin
      others_same = 1'b1;
      for (int s = 0; s < L2LRU_SETS_PER_GROUP; s++) begin
         if (2'(s) != rsp_set[1:0] &&
             lru_q[rsp_set[SET_BITS-1:2]][s] != lru_hist_q[rsp_set[SET_BITS-1:2]][s]) begin
            others_same = 1'b0;
         end
      end
      rsp_ranks = lru_q[rsp_set[SET_BITS-1:2]][rsp_set[1:0]];
   end

   a_ram_order_kept:
   assert property (@(posedge clk) disable iff (rst)
      req_ok && cur_ram && !cur_dma |=> lru_q == $past(lru_q))
      else $error("on-chip RAM access changed replacement order");

   a_dma_order_kept:
   assert property (@(posedge clk) disable iff (rst)
      req_ok && cur_dma |=> lru_q == $past(lru_q))
      else $error("requester access changed replacement order");

   a_hit_made_mru:
   assert property (@(posedge clk) disable iff (rst)
      rsp_valid && rsp_hit && $past(!cur_dma) |->
      rsp_ranks[rsp_way*2 +: 2] == L2LRU_RANK_MRU)
      else $error("hit way not most recent");

   a_group_others_kept:
   assert property (@(posedge clk) disable iff (rst)
      rsp_valid && rsp_hit |-> others_same)
      else $error("hit wrote neighbouring sets of its group");

   a_invalid_first:
   assert property (@(posedge clk) disable iff (rst)
      do_alloc && !(&valid_q[cur_set]) |=> !valid_hist_q[rsp_set][rsp_way])
      else $error("allocation skipped an invalid way");

   a_evict_lru:
   assert property (@(posedge clk) disable iff (rst)
      do_alloc && (&valid_q[cur_set]) |->
      lru_q[cur_grp][cur_slot][victim_way*2 +: 2] == L2LRU_RANK_LRU ##1 evict_valid)
      else $error("eviction did not take least recent way");

   a_block_clears:
   assert property (@(posedge clk) disable iff (rst)
      blk_step && cur_hit |=> !valid_q[$past(cur_set)][$past(hit_way)])
      else $error("block operation left line valid");

   a_reset_invalid:
   assert property (@(posedge clk)
      rst |=> valid_q == '0 && lru_q[0][0] == L2LRU_RANK_RESET)
      else $error("reset did not clear lines and order");

   a_set_mapping:
   assert property (@(posedge clk) disable iff (rst)
      req_ok |=> rsp_valid && rsp_set == $past(req_addr[L2LRU_OFFSET_BITS +: SET_BITS]))
      else $error("set index not taken from line address bits");

   a_block_finishes:
   assert property (@(posedge clk) disable iff (rst)
      start_ok && blk_lines == 16'h0002 |=> blk_busy ##1 blk_busy ##1 (!blk_busy && blk_done))
      else $error("two-line block operation took wrong time");

endmodule : l2lru_cache
`default_nettype wire

/* File: testbench/l2lru_req_model.sv */
// Requester model: processor fetch, data and DMA accesses
`timescale 1ns/100ps
`default_nettype none
module l2lru_req_model import l2lru_pkg::*; #(
   parameter int SET_BITS = 3
) (
   // Clock
   input wire logic clk,
   // Request side
   output var logic req_valid,
   output var logic [31:0] req_addr,
   output var l2lru_src_t req_src,
   output var logic req_alloc,
   // Response side
   input wire logic rsp_valid,
   input wire logic rsp_ram,
   input wire logic rsp_hit,
   input wire logic [1:0] rsp_way,
   input wire logic [SET_BITS-1:0] rsp_set
);
   initial begin
      req_valid = 1'b0;
      req_addr = 32'h0;
      req_src = L2LRU_SRC_PROG;
      req_alloc = 1'b0;
   end

   // Request held for one edge, answer read in the next cycle
   task automatic access(input logic [31:0] a, input l2lru_src_t s, input logic al,
         output logic [SET_BITS+4:0] res);
      @(negedge clk);
      req_valid = 1'b1;
      req_addr = a;
      req_src = s;
      req_alloc = al;
      @(negedge clk);
      res = {rsp_valid, rsp_ram, rsp_hit, rsp_way, rsp_set};
      req_valid = 1'b0;
      // Released address and alloc lines must not keep the last value
      req_addr = ~a;
      req_alloc = ~al;
   endtask : access
endmodule : l2lru_req_model
`default_nettype wire

/* File: testbench/l2lru_cache_tb.sv */
// Self-checking testbench for the cache replacement-state block
`timescale 1ns/100ps
`default_nettype none
module l2lru_cache_tb;
   import l2lru_pkg::*;
   logic clk, rst, req_valid, req_alloc, req_ready, rsp_valid, rsp_ram, rsp_hit;
   logic [31:0] req_addr, evict_addr, blk_addr;
   l2lru_src_t req_src;
   logic [1:0] rsp_way;
   logic [2:0] rsp_set;
   logic evict_valid, blk_start, blk_wbinv, blk_busy, blk_done;
   logic [15:0] blk_lines;
   logic [31:0] ev_q[$];
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;

   l2lru_cache #(.SETS(8)) u_l2lru_cache (.clk(clk), .rst(rst), .req_valid(req_valid),
      .req_addr(req_addr), .req_src(req_src), .req_alloc(req_alloc),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ram(rsp_ram),
      .rsp_hit(rsp_hit), .rsp_way(rsp_way), .rsp_set(rsp_set),
      .evict_valid(evict_valid), .evict_addr(evict_addr), .blk_start(blk_start),
      .blk_wbinv(blk_wbinv), .blk_addr(blk_addr), .blk_lines(blk_lines),
      .blk_busy(blk_busy), .blk_done(blk_done));

   l2lru_req_model #(.SET_BITS(3)) u_l2lru_req_model (.clk(clk), .req_valid(req_valid),
      .req_addr(req_addr), .req_src(req_src), .req_alloc(req_alloc),
      .rsp_valid(rsp_valid), .rsp_ram(rsp_ram), .rsp_hit(rsp_hit), .rsp_way(rsp_way),
      .rsp_set(rsp_set));

   always #20 clk = ~clk;

   // Collect every line that leaves the cache
   always @(posedge clk) begin
      if (evict_valid === 1'b1) begin
         ev_q.push_back(evict_addr);
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         test_done();
      end
   end

   function automatic logic [31:0] la(input int t, input int s);
      return 32'h8000_0000 + 32'(t << 10) + 32'(s << 7);
   endfunction : la

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   // One access and its expected answer; ev of zero means no eviction
   task automatic acc(input logic [31:0] a, input l2lru_src_t s, input logic al,
         input logic h, input logic [1:0] w, input logic [31:0] ev);
      logic [7:0] r;
      logic ram;
      ram = (a - L2LRU_RAM_BASE_RESET) < L2LRU_RAM_SIZE_RESET;
      u_l2lru_req_model.access(a, s, al, r);
      @(negedge clk);
      check(32'(r[7]), 32'h1, "rsp_valid");
      check(32'(r[6]), 32'(ram), "rsp_ram");
      check(32'(r[5]), 32'(h), "rsp_hit");
      if (!ram && (h || al)) check(32'(r[4:3]), 32'(w), "rsp_way");
      check(32'(r[2:0]), 32'(a[9:7]), "rsp_set");
      check(32'(ev_q.size()), (ev == 32'h0) ? 32'h0 : 32'h1, "evict count");
      if (ev_q.size() != 0) check(ev_q.pop_front(), ev, "evict addr");
      check(32'(req_ready), 32'h1, "ready idle");
      ev_q.delete();
   endtask : acc

   task automatic blk(input logic [31:0] a, input logic wb, input logic [15:0] n);
      int c;
      @(negedge clk);
      blk_start = 1'b1;
      blk_wbinv = wb;
      blk_addr = a;
      blk_lines = n;
      c = 0;
      do begin
         @(negedge clk);
         c++;
         if (c == 1) check(32'(blk_busy), 32'h1, "block busy");
         if (c == 1) check(32'(req_ready), 32'h0, "ready in block");
         blk_start = 1'b0;
      end while (blk_done !== 1'b1 && c < 50);
      check(32'(c), 32'((n > 1 ? n : 16'h1) + 1), "block length");
      check(32'(req_ready), 32'h1, "ready after block");
      @(negedge clk);
   endtask : blk

   task automatic test_fill();
      for (int s = 4; s < 7; s++) begin
         for (int t = 0; t < 4; t++) acc(la(t, s), L2LRU_SRC_DATA, 1'b1, 1'b0, 2'(t), 0);
      end
      for (int t = 0; t < 4; t++) acc(la(t, 5), L2LRU_SRC_PROG, 1'b0, 1'b1, 2'(t), 0);
      $display("test fill done");
   endtask : test_fill

   task automatic test_order();
      acc(la(0, 5), L2LRU_SRC_DATA, 1'b0, 1'b1, 2'h0, 0);
      acc(la(2, 5), L2LRU_SRC_PROG, 1'b0, 1'b1, 2'h2, 0);
      acc(la(4, 5), L2LRU_SRC_DATA, 1'b1, 1'b0, 2'h1, la(1, 5));
      acc(la(5, 5), L2LRU_SRC_PROG, 1'b1, 1'b0, 2'h3, la(3, 5));
      $display("test order done");
   endtask : test_order

   task automatic test_group();
      // Set 5 activity must not have aged set 4
      acc(la(4, 4), L2LRU_SRC_DATA, 1'b1, 1'b0, 2'h0, la(0, 4));
      $display("test group done");
   endtask : test_group

   task automatic test_ram();
      for (int i = 0; i < 3; i++) begin
         acc(32'h300 + 32'(i << 10), l2lru_src_t'(i), 1'b1, 1'b0, 2'h0, 0);
      end
      // Way 0 must still be least recent in set 6
      acc(la(4, 6), L2LRU_SRC_DATA, 1'b1, 1'b0, 2'h0, la(0, 6));
      $display("test ram done");
   endtask : test_ram

   task automatic test_block();
      ev_q.delete();
      blk(la(2, 4), 1'b1, 16'h2);
      check(32'(ev_q.size()), 32'h2, "wbinv count");
      if (ev_q.size() == 2) begin
         check(ev_q[0], la(2, 4), "wbinv first");
         check(ev_q[1], la(2, 5), "wbinv second");
      end
      ev_q.delete();
      acc(la(7, 4), L2LRU_SRC_DATA, 1'b1, 1'b0, 2'h2, 0);
      blk(la(3, 4), 1'b0, 16'h1);
      check(32'(ev_q.size()), 32'h0, "inval no evict");
      ev_q.delete();
      acc(la(8, 4), L2LRU_SRC_PROG, 1'b1, 1'b0, 2'h3, 0);
      blk(la(0, 0), 1'b0, 16'h0);
      $display("test block done");
   endtask : test_block

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      blk_start = 1'b0;
      blk_wbinv = 1'b0;
      blk_addr = 32'h0;
      blk_lines = 16'h0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      test_fill();
      test_order();
      test_group();
      test_ram();
      test_block();
      test_done();
   end
endmodule : l2lru_cache_tb
`default_nettype wire
